// File: include/area_bus_pkg.sv
// package: register map, reset values, modes and carriers of the area bus configuration
package area_bus_pkg;
  localparam int AREAS = 8;
  localparam int AREA_MSB = 23;
  localparam int AREA_LSB = 21;
  localparam int ADDR_W = 24;
  // ==========================================================
  // register map
  localparam logic [7:0] OFF_WIDTH = 8'h00;
  localparam logic [7:0] OFF_STATE = 8'h04;
  localparam logic [7:0] OFF_UPPER = 8'h08;
  localparam logic [7:0] OFF_LOWER = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  // ==========================================================
  // reset values
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ALL_ZEROS = 8'h00;
  // ==========================================================
  // operating modes
  localparam logic [2:0] MODE_2 = 3'h2;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_6 = 3'h6;
  localparam logic [2:0] MODE_7 = 3'h7;
  // ==========================================================
  // status register fields
  localparam int ST_BUS16 = 0;
  localparam int ST_SINGLE = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_INIT = 3;
  localparam int ST_MODE_LSB = 4;
  // ==========================================================
  // access lengths in states (clock cycles)
  localparam logic [2:0] TWO_STATES = 3'h2;
  localparam logic [2:0] THREE_STATES = 3'h3;
  localparam logic [2:0] INTERNAL_STATES = 3'h2;

  typedef struct packed {
    logic width16;
    logic three_state;
    logic [1:0] waits;
  } area_cfg_s;

  typedef struct packed {
    logic [7:0] width;
    logic [7:0] state;
    logic [7:0] upper;
    logic [7:0] lower;
  } cfg_regs_s;
endpackage

// File: verification/area_wait_partner.sv
// partner: external device that stretches accesses through the wait pin
`timescale 1ns/1ns
module area_wait_partner
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [3:0] lead,
  input wire logic [3:0] stall,
  output logic ext_wait_n
);
  logic [4:0] cnt;
  // ==========================================================
  // cycles since the access was taken; pin pulled up outside the window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= 5'h00;
    else if (start)
      cnt <= 5'h01;
    else if (cnt != 5'h00 && cnt != 5'h1f)
      cnt <= cnt + 5'h01;
  end
  assign ext_wait_n = !(cnt >= {1'b0, lead} && cnt < {1'b0, lead} + {1'b0, stall});
endmodule

// File: verification/external_area_bus_config_bench.sv
// bench: register, reset, standby and access-timing checks of the area bus configuration
`timescale 1ns/1ns
module external_area_bus_config_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ext_wait_n, acc_ready, acc_done, acc_is_internal, bus_16bit, port4_gpio;
  logic [2:0] op_mode = 3'h1;
  logic hw_standby = 1'b0;
  logic sw_standby = 1'b0;
  logic acc_req = 1'b0;
  logic acc_internal = 1'b0;
  logic [area_bus_pkg::ADDR_W-1:0] acc_addr = '0;
  logic [2:0] acc_area;
  area_bus_pkg::area_cfg_s acc_cfg;
  logic [3:0] lead = 4'h2;
  logic [31:0] rd;
  logic last_err;
  logic [7:0] st;
  logic [15:0] waits = 16'he41b;
  logic [7:0] width = 8'h5a;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;

  always #5 pclk = ~pclk;

  external_area_bus_config i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .op_mode(op_mode), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .acc_req(acc_req), .acc_internal(acc_internal),
    .acc_addr(acc_addr), .ext_wait_n(ext_wait_n), .acc_ready(acc_ready),
    .acc_done(acc_done), .acc_area(acc_area), .acc_cfg(acc_cfg),
    .acc_is_internal(acc_is_internal), .bus_16bit(bus_16bit), .port4_gpio(port4_gpio));

  area_wait_partner i_partner (.pclk(pclk), .presetn(presetn), .start(acc_req & acc_ready),
    .lead(lead), .stall(4'h2), .ext_wait_n(ext_wait_n));

  // ==========================================================
  // shared tasks
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // 33 bits so that the error flag rides above a full read word
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD time %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    apb(1'b0, addr, 32'h0);
    chk({last_err, rd}, {1'b0, 24'h0, exp});
  endtask

  task automatic pins(input logic [1:0] exp);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk({bus_16bit, port4_gpio}, exp);
  endtask

  task automatic do_reset(input logic [2:0] mode);
    @(posedge pclk);
    presetn <= 1'b0;
    op_mode <= mode;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  // one access; a two-state or on-chip access must ignore the stretched wait pin
  task automatic access(input logic [2:0] area, input logic intl, input logic [1:0] w,
    input logic three, input logic wide);
    int n;
    @(posedge pclk);
    acc_req <= 1'b1;
    acc_internal <= intl;
    acc_addr <= {area, 21'h0};
    lead <= three ? 4'h3 + {2'h0, w} : 4'h2;
    @(posedge pclk);
    acc_req <= 1'b0;
    n = 1;
    @(negedge pclk);
    while (acc_done !== 1'b1 && n < 40)
    begin
      @(negedge pclk);
      n++;
    end
    chk(n, three ? 5 + w : 2);
    chk({acc_is_internal, acc_area, acc_cfg}, {intl, area, wide, three, w});
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    do_reset(3'h1);
    rd_chk(area_bus_pkg::OFF_WIDTH, 8'hff);
    rd_chk(area_bus_pkg::OFF_STATE, 8'hff);
    rd_chk(area_bus_pkg::OFF_UPPER, 8'hff);
    rd_chk(area_bus_pkg::OFF_LOWER, 8'hff);
    pins(2'b01);
    apb(1'b1, area_bus_pkg::OFF_UPPER, {24'h0, waits[15:8]});
    apb(1'b1, area_bus_pkg::OFF_LOWER, {24'hffffff, waits[7:0]});
    rd_chk(area_bus_pkg::OFF_UPPER, 8'he4);
    rd_chk(area_bus_pkg::OFF_LOWER, 8'h1b);
    apb(1'b0, 8'h14, 32'h0);
    chk({last_err, rd}, {1'b1, 32'h0});
    apb(1'b1, area_bus_pkg::OFF_WIDTH, 32'hfe);
    pins(2'b10);
    apb(1'b1, area_bus_pkg::OFF_WIDTH, {24'h0, width});
    rd_chk(area_bus_pkg::OFF_WIDTH, width);
    for (int s = 0; s < 2; s++)
    begin
      st = s == 0 ? 8'h55 : 8'haa;
      apb(1'b1, area_bus_pkg::OFF_STATE, {24'h0, st});
      rd_chk(area_bus_pkg::OFF_STATE, st);
      for (int a = 0; a < 8; a++)
        access(a[2:0], 1'b0, waits[2*a +: 2], st[a], !width[a]);
    end
    access(3'h5, 1'b1, 2'h0, 1'b0, 1'b1);
    @(posedge pclk);
    sw_standby <= 1'b1;
    @(negedge pclk);
    chk(acc_ready, 1'b0);
    rd_chk(area_bus_pkg::OFF_WIDTH, width);
    rd_chk(area_bus_pkg::OFF_STATE, 8'haa);
    rd_chk(area_bus_pkg::OFF_UPPER, 8'he4);
    sw_standby <= 1'b0;
    hw_standby <= 1'b1;
    repeat (2) @(posedge pclk);
    hw_standby <= 1'b0;
    @(posedge pclk);
    rd_chk(area_bus_pkg::OFF_WIDTH, 8'hff);
    rd_chk(area_bus_pkg::OFF_STATE, 8'hff);
    rd_chk(area_bus_pkg::OFF_LOWER, 8'hff);
    for (int m = 1; m < 8; m++)
    begin
      do_reset(m[2:0]);
      rd_chk(area_bus_pkg::OFF_WIDTH, (m == 2 || m == 4) ? 8'h00 : 8'hff);
      pins((m == 2 || m == 4) ? 2'b10 : 2'b01);
      rd_chk(area_bus_pkg::OFF_STATUS, {1'b0, m[2:0], 2'b00, (m >= 6), (m == 2 || m == 4)});
      apb(1'b1, area_bus_pkg::OFF_WIDTH, 32'h0);
      pins(m >= 6 ? 2'b01 : 2'b10);
    end
    report_and_stop();
  end
endmodule

// File: verilog/area_access_timer.sv
// access timer: counts the states of one access and stretches it on the wait pin
`timescale 1ns/1ns
module area_access_timer
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic internal,
  input wire area_bus_pkg::area_cfg_s cfg,
  input wire logic ext_wait_n,
  output logic busy,
  output logic done
);
  typedef enum logic {IDLE, RUN} timer_e;

  timer_e phase;
  timer_e next_phase;
  logic [2:0] left;
  logic [2:0] next_left;
  logic pin_ok;
  logic next_pin_ok;
  logic hold;

  // ==========================================================
  // state counting
  assign hold = pin_ok && !ext_wait_n; // R14
  assign busy = (phase == RUN);
  assign done = (phase == RUN) && (left == 3'h0) && !hold;

  always_comb
  begin
    next_phase = phase;
    next_left = left;
    next_pin_ok = pin_ok;
    case (phase)
      IDLE:
      begin
        if (start)
        begin
          next_phase = RUN;
          next_pin_ok = !internal && cfg.three_state; // R14
          if (internal)
            next_left = area_bus_pkg::INTERNAL_STATES - 3'h1; // R9
          else if (cfg.three_state)
            next_left = area_bus_pkg::THREE_STATES + {1'b0, cfg.waits} - 3'h1; // R10 R11
          else
            next_left = area_bus_pkg::TWO_STATES - 3'h1; // R7
        end
      end
      RUN:
      begin
        if (left != 3'h0)
          next_left = left - 3'h1;
        else if (!hold)
          next_phase = IDLE;
      end
      default:
        next_phase = IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= IDLE;
      left <= 3'h0;
      pin_ok <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      left <= next_left;
      pin_ok <= next_pin_ok;
    end
  end
endmodule

// File: verilog/external_area_bus_config.sv
// external area bus configuration: apb register bank and per-access area settings
//
// Contract
// R1 - width bit n: 0 16-bit, 1 8-bit
// R2 - all width bits one gives 8-bit bus
// R3 - any width bit zero gives 16-bit bus
// R4 - width reset ones, zeros in modes 2,4
// R5 - software standby keeps all register contents
// R6 - on-chip width fixed; single-chip ignores width
// R7 - state bit n: 0 two-state, 1 three-state
// R8 - state register resets to all ones
// R9 - on-chip accesses take fixed state count
// R10 - upper wait fields areas 7..4, 0-3 waits
// R11 - program waits only in three-state areas
// R12 - both wait registers reset to ones
// R13 - lower wait fields areas 3..0, same code
// R14 - wait pin honoured only in three-state areas
// R15 - area settings latched at access start
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module external_area_bus_config
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] op_mode,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic acc_req,
  input wire logic acc_internal,
  input wire logic [area_bus_pkg::ADDR_W-1:0] acc_addr,
  input wire logic ext_wait_n,
  output logic acc_ready,
  output logic acc_done,
  output logic [2:0] acc_area,
  output area_bus_pkg::area_cfg_s acc_cfg,
  output logic acc_is_internal,
  output logic bus_16bit,
  output logic port4_gpio
);
  area_bus_pkg::cfg_regs_s regs;
  area_bus_pkg::cfg_regs_s next_regs;
  area_bus_pkg::area_cfg_s area_cfg [area_bus_pkg::AREAS];
  logic init_pending;
  logic next_init_pending;
  logic [31:0] next_prdata;
  logic [2:0] next_acc_area;
  area_bus_pkg::area_cfg_s next_acc_cfg;
  logic next_acc_is_internal;
  logic next_bus_16bit;
  logic next_port4_gpio;
  logic wr_en;
  logic mapped;
  logic single_chip;
  logic reinit;
  logic [7:0] width_init;
  logic [15:0] wait_word;
  logic [2:0] req_area;
  logic start;
  logic busy;

  // ==========================================================
  // apb decode
  assign wr_en = psel && penable && pwrite;
  assign mapped = (paddr == area_bus_pkg::OFF_WIDTH) || (paddr == area_bus_pkg::OFF_STATE)
    || (paddr == area_bus_pkg::OFF_UPPER) || (paddr == area_bus_pkg::OFF_LOWER)
    || (paddr == area_bus_pkg::OFF_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ==========================================================
  // configuration registers
  assign single_chip = (op_mode == area_bus_pkg::MODE_6) || (op_mode == area_bus_pkg::MODE_7);
  assign reinit = hw_standby || init_pending;
  assign width_init = ((op_mode == area_bus_pkg::MODE_2) || (op_mode == area_bus_pkg::MODE_4))
    ? area_bus_pkg::ALL_ZEROS : area_bus_pkg::ALL_ONES; // R4

  always_comb
  begin
    next_regs = regs;
    next_init_pending = 1'b0;
    if (reinit)
    begin
      next_regs.width = width_init; // R4
      next_regs.state = area_bus_pkg::ALL_ONES; // R8
      next_regs.upper = area_bus_pkg::ALL_ONES; // R12
      next_regs.lower = area_bus_pkg::ALL_ONES; // R12
    end
    else if (wr_en)
    begin
      // sw_standby does not touch the registers
      case (paddr) // R5
        area_bus_pkg::OFF_WIDTH: next_regs.width = pwdata[7:0];
        area_bus_pkg::OFF_STATE: next_regs.state = pwdata[7:0];
        area_bus_pkg::OFF_UPPER: next_regs.upper = pwdata[7:0];
        area_bus_pkg::OFF_LOWER: next_regs.lower = pwdata[7:0];
        default: next_regs = regs;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      regs <= {4{area_bus_pkg::ALL_ONES}};
      init_pending <= 1'b1;
    end
    else
    begin
      regs <= next_regs;
      init_pending <= next_init_pending;
    end
  end

  // ==========================================================
  // read data, captured in the setup cycle
  always_comb
  begin
    next_prdata = prdata;
    if (psel && !penable)
    begin
      next_prdata = 32'h0;
      case (paddr)
        area_bus_pkg::OFF_WIDTH: next_prdata[7:0] = regs.width;
        area_bus_pkg::OFF_STATE: next_prdata[7:0] = regs.state;
        area_bus_pkg::OFF_UPPER: next_prdata[7:0] = regs.upper;
        area_bus_pkg::OFF_LOWER: next_prdata[7:0] = regs.lower;
        area_bus_pkg::OFF_STATUS:
        begin
          next_prdata[area_bus_pkg::ST_BUS16] = bus_16bit;
          next_prdata[area_bus_pkg::ST_SINGLE] = single_chip;
          next_prdata[area_bus_pkg::ST_BUSY] = busy;
          next_prdata[area_bus_pkg::ST_INIT] = init_pending;
          next_prdata[area_bus_pkg::ST_MODE_LSB +: 3] = op_mode;
        end
        default: next_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else
      prdata <= next_prdata;
  end

  // ==========================================================
  // per-area settings
  assign wait_word = {regs.upper, regs.lower}; // R10 R13

  genvar gi;
  generate
    for (gi = 0; gi < area_bus_pkg::AREAS; gi++)
    begin : g_area
      assign area_cfg[gi].width16 = !regs.width[gi]; // R1
      assign area_cfg[gi].three_state = regs.state[gi]; // R7
      assign area_cfg[gi].waits = wait_word[2*gi +: 2]; // R10 R13
    end
  endgenerate

  // ==========================================================
  // chip-wide bus mode
  always_comb
  begin
    next_bus_16bit = 1'b0;
    next_port4_gpio = 1'b1;
    if (!single_chip) // R6
    begin
      next_bus_16bit = (regs.width != area_bus_pkg::ALL_ONES); // R2 R3
      next_port4_gpio = (regs.width == area_bus_pkg::ALL_ONES); // R2
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_16bit <= 1'b0;
      port4_gpio <= 1'b1;
    end
    else
    begin
      bus_16bit <= next_bus_16bit;
      port4_gpio <= next_port4_gpio;
    end
  end

  // ==========================================================
  // access start: decode area and latch its settings
  assign acc_ready = !busy && !sw_standby && !reinit;
  assign start = acc_req && acc_ready;
  assign req_area = acc_addr[area_bus_pkg::AREA_MSB:area_bus_pkg::AREA_LSB];

  always_comb
  begin
    next_acc_area = acc_area;
    next_acc_cfg = acc_cfg;
    next_acc_is_internal = acc_is_internal;
    if (start)
    begin
      next_acc_area = req_area; // R15
      next_acc_is_internal = acc_internal;
      next_acc_cfg = area_cfg[req_area]; // R15
      if (acc_internal)
      begin
        next_acc_cfg.width16 = 1'b1; // R6
        next_acc_cfg.three_state = 1'b0; // R9
        next_acc_cfg.waits = 2'h0; // R9
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_area <= 3'h0;
      acc_cfg <= '0;
      acc_is_internal <= 1'b0;
    end
    else
    begin
      acc_area <= next_acc_area;
      acc_cfg <= next_acc_cfg;
      acc_is_internal <= next_acc_is_internal;
    end
  end

  area_access_timer u_timer
  (
    .pclk(pclk),
    .presetn(presetn),
    .start(start),
    .internal(acc_internal),
    .cfg(area_cfg[req_area]),
    .ext_wait_n(ext_wait_n),
    .busy(busy),
    .done(acc_done)
  );

  // ==========================================================
  // assertion helpers: cycles of the access and pin stretch seen
  logic [3:0] run_cnt;
  logic saw_wait;
  logic [3:0] expect_cnt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_cnt <= 4'h0;
      saw_wait <= 1'b0;
    end
    else if (start)
    begin
      run_cnt <= 4'h1;
      saw_wait <= 1'b0;
    end
    else if (busy)
    begin
      run_cnt <= run_cnt + 4'h1;
      saw_wait <= saw_wait || !ext_wait_n;
    end
  end

  assign expect_cnt = acc_is_internal ? {1'b0, area_bus_pkg::INTERNAL_STATES}
    : acc_cfg.three_state ? {1'b0, area_bus_pkg::THREE_STATES} + {2'h0, acc_cfg.waits}
    : {1'b0, area_bus_pkg::TWO_STATES};

  // ==========================================================
  // assertions
  property p_width_bit;
    @(posedge pclk) disable iff (!presetn)
      start && !acc_internal |=> acc_cfg.width16 == !$past(regs.width[req_area]);
  endproperty
  a_width_bit: assert property (p_width_bit) else $error("area width not latched"); // R1

  property p_bus8;
    @(posedge pclk) disable iff (!presetn)
      regs.width == area_bus_pkg::ALL_ONES && !single_chip |=> !bus_16bit && port4_gpio;
  endproperty
  a_bus8: assert property (p_bus8) else $error("8-bit bus mode not taken"); // R2

  property p_bus16;
    @(posedge pclk) disable iff (!presetn)
      regs.width != area_bus_pkg::ALL_ONES && !single_chip |=> bus_16bit && !port4_gpio;
  endproperty
  a_bus16: assert property (p_bus16) else $error("16-bit bus mode not taken"); // R3

  property p_width_init;
    @(posedge pclk) disable iff (!presetn)
      hw_standby |=> regs.width == $past(width_init);
  endproperty
  a_width_init: assert property (p_width_init) else $error("width init value wrong"); // R4

  property p_keep;
    @(posedge pclk) disable iff (!presetn)
      sw_standby && !reinit && !wr_en |=> $stable(regs);
  endproperty
  a_keep: assert property (p_keep) else $error("registers lost in standby"); // R5

  property p_single;
    @(posedge pclk) disable iff (!presetn)
      single_chip [*2] |-> !bus_16bit && port4_gpio;
  endproperty
  a_single: assert property (p_single) else $error("single-chip bus mode wrong"); // R6

  property p_two_state;
    @(posedge pclk) disable iff (!presetn)
      start && !acc_internal && !area_cfg[req_area].three_state |-> ##2 acc_done;
  endproperty
  a_two_state: assert property (p_two_state) else $error("two-state access length wrong"); // R7

  property p_state_init;
    @(posedge pclk) disable iff (!presetn)
      hw_standby |=> regs.state == area_bus_pkg::ALL_ONES;
  endproperty
  a_state_init: assert property (p_state_init) else $error("state register init wrong"); // R8

  property p_internal;
    @(posedge pclk) disable iff (!presetn)
      start && acc_internal |-> ##2 acc_done;
  endproperty
  a_internal: assert property (p_internal) else $error("on-chip access length wrong"); // R9

  property p_wait_len;
    @(posedge pclk) disable iff (!presetn)
      acc_done && !saw_wait |-> run_cnt == expect_cnt;
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("program wait count wrong"); // R10 R11 R13

  property p_wait_init;
    @(posedge pclk) disable iff (!presetn)
      hw_standby |=> regs.upper == area_bus_pkg::ALL_ONES && regs.lower == area_bus_pkg::ALL_ONES;
  endproperty
  a_wait_init: assert property (p_wait_init) else $error("wait registers init wrong"); // R12

  property p_pin_ignored;
    @(posedge pclk) disable iff (!presetn)
      acc_done && !acc_cfg.three_state |-> run_cnt == expect_cnt;
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("wait pin stretched access"); // R14

  property p_latched;
    @(posedge pclk) disable iff (!presetn)
      busy && !start |=> $stable(acc_cfg) && $stable(acc_area);
  endproperty
  a_latched: assert property (p_latched) else $error("settings changed mid access"); // R15

  c_three_wait: cover property (@(posedge pclk) acc_done && acc_cfg.three_state && run_cnt > 4'h3);
  c_pin_wait: cover property (@(posedge pclk) acc_done && saw_wait && acc_cfg.three_state);
  c_write_busy: cover property (@(posedge pclk) wr_en && busy);
  c_sw_standby: cover property (@(posedge pclk) sw_standby && acc_req);
endmodule
